// ===== src/scd_decoder.sv
// Command and clock-enable state decoder of the memory device
`timescale 1ns/1ps
module scd_decoder #(
  parameter int BANK_W = 3,
  parameter int ROW_W = 16,
  parameter int COL_W = 10,
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic termination_control,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic on_the_fly_select,
  input wire logic fixed_chop_four,
  output logic cmd_valid,
  output scd_pkg::scd_cmd_t cmd_code,
  output logic [BANK_W-1:0] cmd_bank,
  output logic [ROW_W-1:0] row_address,
  output logic [COL_W-1:0] column_address,
  output logic [ADDR_W-1:0] mode_operand,
  output logic [1:0] mode_register_sel,
  output logic chop_four_burst,
  output logic autoclose,
  output logic burst_busy,
  output logic [(1<<BANK_W)-1:0] bank_open,
  output scd_pkg::scd_pwr_t power_state,
  output logic device_idle
);
  localparam int NB = 1 << BANK_W;
  scd_cmd_if smp ();

  // Synchronised strobes, clock enable and its previous level
  scd_sampler u_smp (
    .clk(clk),
    .reset_n(reset_n),
    .pins({cs_n, ras_n, cas_n, we_n, cke}),
    .smp(smp)
  );

  typedef struct packed {
    // Address passes the same two stages to stay aligned with strobes
    logic [BANK_W-1:0] ba1;
    logic [BANK_W-1:0] ba2;
    logic [ADDR_W-1:0] ad1;
    logic [ADDR_W-1:0] ad2;
    logic valid;
    scd_pkg::scd_cmd_t code;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [ADDR_W-1:0] op;
    logic [1:0] mreg;
    logic chop;
    logic ap;
    logic [2:0] burst;
    logic busy;
    logic [NB-1:0] open;
    scd_pkg::scd_pwr_t pwr;
    logic idle;
  } scd_st_t;
  scd_st_t q, d;

  logic hh, quiet_cmd, fall, rise, sel;
  logic [2:0] strobes;
  logic close_sel;
  logic [BANK_W-1:0] bank_s2;
  logic [ADDR_W-1:0] addr_s2;

  // Address as seen at the same edge as the strobes
  assign bank_s2 = q.ba2;
  assign addr_s2 = q.ad2;

  // Termination control is deliberately left unread
  always_comb begin
    strobes = {smp.ras_n, smp.cas_n, smp.we_n};
    sel = !smp.cs_n;
    close_sel = addr_s2[scd_pkg::SCD_PRE_SEL_POS];
    hh = smp.cke_prev && smp.cke;
    fall = smp.cke_prev && !smp.cke;
    rise = !smp.cke_prev && smp.cke;
    quiet_cmd = !sel || strobes == 3'b111;
  end

  // Decode and state update; pins use sampled levels, chop mode inputs are read directly
  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.code = scd_pkg::SCD_CMD_NONE;
    // Address pins pass two stages; nothing reads the first
    d.ba1 = bank_addr;
    d.ba2 = q.ba1;
    d.ad1 = addr;
    d.ad2 = q.ad1;
    // Burst countdown; nothing can shorten it
    if (q.burst != 3'h0) begin
      d.burst = q.burst - 3'h1;
    end
    case (q.pwr)
      scd_pkg::SCD_ST_RUN: begin
        if (hh && sel) begin
          d.valid = 1'b1;
          d.bank = bank_s2;
          case (strobes)
            3'b000: begin
              d.code = scd_pkg::SCD_CMD_MRW;
              d.mreg = bank_s2[1:0];
              d.op = addr_s2;
            end
            3'b001: d.code = scd_pkg::SCD_CMD_REF;
            3'b010: begin
              if (close_sel) begin
                d.code = scd_pkg::SCD_CMD_PRE_ALL;
                d.open = '0;
              end else begin
                d.code = scd_pkg::SCD_CMD_PRE;
                d.open[bank_s2] = 1'b0;
              end
            end
            3'b011: begin
              d.code = scd_pkg::SCD_CMD_OPEN;
              d.row = addr_s2[ROW_W-1:0];
              d.open[bank_s2] = 1'b1;
            end
            3'b100, 3'b101: begin
              d.code = strobes[0] ? scd_pkg::SCD_CMD_RD :
                scd_pkg::SCD_CMD_WR;
              d.col = addr_s2[COL_W-1:0];
              d.ap = close_sel;
              d.chop = on_the_fly_select ?
                !addr_s2[scd_pkg::SCD_CHOP_SEL_POS] : fixed_chop_four;
              if (q.burst == 3'h0) begin
                d.burst = d.chop ? scd_pkg::SCD_BURST_CYC_CHOP :
                  scd_pkg::SCD_BURST_CYC_FULL;
              end
              // Autoclose frees the bank at once, not at burst end
              if (close_sel) begin
                d.open[bank_s2] = 1'b0;
              end
            end
            3'b110: d.code = close_sel ? scd_pkg::SCD_CMD_ZQL :
              scd_pkg::SCD_CMD_ZQS;
            default: d.valid = 1'b0;
          endcase
        end else if (fall && sel && strobes == 3'b001 &&
                     q.idle) begin
          d.valid = 1'b1;
          d.code = scd_pkg::SCD_CMD_SR_IN;
          d.pwr = scd_pkg::SCD_ST_SR;
        end else if (fall && quiet_cmd) begin
          d.valid = 1'b1;
          d.code = scd_pkg::SCD_CMD_PD_IN;
          d.pwr = scd_pkg::SCD_ST_PD;
        end
      end
      scd_pkg::SCD_ST_PD: begin
        if (rise && quiet_cmd) begin
          d.valid = 1'b1;
          d.code = scd_pkg::SCD_CMD_PD_OUT;
          d.pwr = scd_pkg::SCD_ST_RUN;
        end
      end
      scd_pkg::SCD_ST_SR: begin
        // Exit needs the rising enable with no-op or deselect, no prior clock
        if (rise && quiet_cmd) begin
          d.valid = 1'b1;
          d.code = scd_pkg::SCD_CMD_SR_OUT;
          d.pwr = scd_pkg::SCD_ST_RUN;
        end
      end
      default: d.pwr = scd_pkg::SCD_ST_RUN;
    endcase
    // Busy kept in a flop so the output needs no gate
    d.busy = d.burst != 3'h0;
    // Idle: all closed, no burst, enable high, running
    d.idle = d.open == '0 && d.burst == 3'h0 && smp.cke &&
      d.pwr == scd_pkg::SCD_ST_RUN;
  end

  // Synchronous reset; clears this state, while the sampler loads strobes high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
      q.burst <= scd_pkg::SCD_BURST_RST;
      q.open <= '0;
      q.pwr <= scd_pkg::SCD_ST_RUN;
    end else begin
      q <= d;
    end
  end

  assign cmd_valid = q.valid;
  assign cmd_code = q.code;
  assign cmd_bank = q.bank;
  assign row_address = q.row;
  assign column_address = q.col;
  assign mode_operand = q.op;
  assign mode_register_sel = q.mreg;
  assign chop_four_burst = q.chop;
  assign autoclose = q.ap;
  assign burst_busy = q.busy;
  assign bank_open = q.open;
  assign power_state = q.pwr;
  assign device_idle = q.idle;

  // Power-down leaves only through a rise with no-op or deselect
  a_pd_exit_cause: assert property (
    @(posedge clk) disable iff (!reset_n)
    q.pwr == scd_pkg::SCD_ST_PD && d.pwr == scd_pkg::SCD_ST_RUN
    |-> rise && quiet_cmd) else $error("power-down left wrongly");
  a_lowlow_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    q.pwr != scd_pkg::SCD_ST_RUN && !smp.cke_prev && !smp.cke
    |=> $stable(q.pwr)) else $error("state moved with enable low");
  a_selfref_entry: assert property (
    @(posedge clk) disable iff (!reset_n)
    q.pwr == scd_pkg::SCD_ST_RUN && fall && sel && strobes == 3'b001
    && q.idle |=> q.pwr == scd_pkg::SCD_ST_SR)
    else $error("no self-refresh entry");
  a_pdown_entry: assert property (
    @(posedge clk) disable iff (!reset_n)
    q.pwr == scd_pkg::SCD_ST_RUN && fall && quiet_cmd
    |=> q.pwr == scd_pkg::SCD_ST_PD && q.code == scd_pkg::SCD_CMD_PD_IN)
    else $error("no power-down entry");
  a_no_op_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    hh && quiet_cmd |=> !q.valid) else $error("no-op made command");
  a_burst_runs: assert property (
    @(posedge clk) disable iff (!reset_n)
    q.burst != 3'h0 |=> q.burst == $past(q.burst) - 3'h1)
    else $error("burst cut short");
  a_all_close: assert property (
    @(posedge clk) disable iff (!reset_n)
    q.pwr == scd_pkg::SCD_ST_RUN && hh && sel && strobes == 3'b010
    && close_sel |=> q.open == '0) else $error("all-bank close failed");
  // Select bit is taken from the decode edge, not the next one
  a_zq_kind: assert property (
    @(posedge clk) disable iff (!reset_n)
    q.pwr == scd_pkg::SCD_ST_RUN && hh && sel && strobes == 3'b110
    |=> q.code == ($past(close_sel) ? scd_pkg::SCD_CMD_ZQL :
    scd_pkg::SCD_CMD_ZQS)) else $error("calibration kind wrong");
  a_idle_meaning: assert property (
    @(posedge clk) disable iff (!reset_n)
    q.idle |-> q.open == '0 && q.burst == 3'h0)
    else $error("idle while busy");
endmodule

// ===== src/scd_pkg.sv
// Package of constants and types for the command and clock-enable decoder
package scd_pkg;
  // Command codes put out by the decoder
  typedef enum logic [3:0] {
    SCD_CMD_NONE = 4'h0,
    SCD_CMD_MRW = 4'h1,
    SCD_CMD_REF = 4'h2,
    SCD_CMD_PRE = 4'h3,
    SCD_CMD_PRE_ALL = 4'h4,
    SCD_CMD_OPEN = 4'h5,
    SCD_CMD_WR = 4'h6,
    SCD_CMD_RD = 4'h7,
    SCD_CMD_ZQL = 4'h8,
    SCD_CMD_ZQS = 4'h9,
    SCD_CMD_SR_IN = 4'ha,
    SCD_CMD_SR_OUT = 4'hb,
    SCD_CMD_PD_IN = 4'hc,
    SCD_CMD_PD_OUT = 4'hd
  } scd_cmd_t;
  // Power state, Gray coded along idle, power-down, self-refresh
  typedef enum logic [1:0] {
    SCD_ST_RUN = 2'h0,
    SCD_ST_PD = 2'h1,
    SCD_ST_SR = 2'h3
  } scd_pwr_t;
  // Bit positions inside the address bus
  localparam int SCD_PRE_SEL_POS = 10;
  localparam int SCD_CHOP_SEL_POS = 12;
  // Burst beats on the command clock (eight beats, double rate)
  localparam logic [2:0] SCD_BURST_CYC_FULL = 3'h4;
  localparam logic [2:0] SCD_BURST_CYC_CHOP = 3'h2;
  // Reset values
  localparam logic [7:0] SCD_BANKS_RST = 8'h00;
  // Pin stages: strobes high, clock enable low
  localparam logic [4:0] SCD_PINS_RST = 5'h1e;
  localparam logic [2:0] SCD_BURST_RST = 3'h0;
endpackage

// ===== src/scd_cmd_if.sv
// Interface carrying the strobes sampled at one clock edge
`timescale 1ns/1ps
interface scd_cmd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic cke_prev;
  modport src (output cs_n, ras_n, cas_n, we_n, cke, cke_prev);
  modport dst (input cs_n, ras_n, cas_n, we_n, cke, cke_prev);
endinterface

// ===== src/scd_sampler.sv
// Two-stage synchroniser for the command strobes plus clock-enable history
`timescale 1ns/1ps
module scd_sampler (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] pins,
  scd_cmd_if.src smp
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic cke_prev;
  } scd_smp_t;
  scd_smp_t q, d;

  // Next stage values; only s2 is read by logic
  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.cke_prev = q.s2[0];
  end

  // Strobes idle high, clock enable idle low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '{scd_pkg::SCD_PINS_RST, scd_pkg::SCD_PINS_RST, 1'b0};
    end else begin
      q <= d;
    end
  end

  assign smp.cs_n = q.s2[4];
  assign smp.ras_n = q.s2[3];
  assign smp.cas_n = q.s2[2];
  assign smp.we_n = q.s2[1];
  assign smp.cke = q.s2[0];
  assign smp.cke_prev = q.cke_prev;
endmodule

// ===== verif/scd_ctrl_model.sv
// Memory controller model driving the command pins
`timescale 1ns/1ps
module scd_ctrl_model (
  input wire logic clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic cke,
  output logic termination_control,
  output logic [2:0] ba,
  output logic [15:0] a
);
  // Idle bus is a no-op with clock enable high
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    cke = 1'b1;
    termination_control = 1'b0;
    ba = 3'h0;
    a = 16'h0000;
  end

  // Termination toggles freely so decoding must ignore it
  always @(posedge clk) begin
    termination_control <= #1 ~termination_control;
  end

  // One command for one edge, then back to no-op; the enable level
  // is kept, and the caller spaces commands for the minimum pulse
  task send(input logic [3:0] s, input logic k, input logic [2:0] b,
    input logic [15:0] ad);
    {cs_n, ras_n, cas_n, we_n} = s;
    cke = k;
    ba = b;
    a = ad;
    @(posedge clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    a = ~ad;
  endtask
endmodule

// ===== verif/sdram_command_cke_decoder_test.sv
// Self-checking bench for the command and clock-enable decoder
`timescale 1ns/1ps
module sdram_command_cke_decoder_test;
  logic clk, reset_n, fly, fc4, cs_n, ras_n, cas_n, we_n, cke, term;
  logic cmd_valid, chop, ac, busy, idle, bz;
  logic [2:0] ba, bank;
  logic [15:0] a, row, mop;
  logic [9:0] col;
  logic [1:0] msel;
  logic [7:0] bopen;
  scd_pkg::scd_cmd_t code;
  scd_pkg::scd_pwr_t pwr;
  int num_errors, total_checks;

  scd_ctrl_model i_ctrl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .cke(cke), .termination_control(term),
    .ba(ba), .a(a));

  scd_decoder i_scd_decoder (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
    .termination_control(term), .bank_addr(ba), .addr(a),
    .on_the_fly_select(fly), .fixed_chop_four(fc4),
    .cmd_valid(cmd_valid), .cmd_code(code), .cmd_bank(bank),
    .row_address(row), .column_address(col), .mode_operand(mop),
    .mode_register_sel(msel), .chop_four_burst(chop), .autoclose(ac),
    .burst_busy(busy), .bank_open(bopen), .power_state(pwr),
    .device_idle(idle));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Issue one command, wait bounded for the pulse, then let bursts end
  task cmd(input logic [3:0] s, input logic k, input logic [2:0] b,
    input logic [15:0] ad, input scd_pkg::scd_cmd_t e);
    int n;
    i_ctrl.send(s, k, b, ad);
    n = 0;
    while (cmd_valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    bz = busy;
    chk(cmd_valid === 1'b1 ? code : scd_pkg::SCD_CMD_NONE, e, "code");
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Hang guard
  initial begin
    #200000;
    num_errors++;
    $display("unexpected at %0t: run timed out", $time);
    summarize();
  end

  initial begin
    reset_n = 1'b0;
    fly = 1'b1;
    fc4 = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk(pwr, scd_pkg::SCD_ST_RUN, "pwr");
    chk(bopen, 8'h00, "banks");
    // Enable history starts low; let both stages see it high first
    repeat (3) @(posedge clk);
    #1;
    cmd(4'h0, 1, 3'h6, 16'h0a5c, scd_pkg::SCD_CMD_MRW);
    chk(msel, 2'h2, "msel");
    chk(mop, 16'h0a5c, "operand");
    cmd(4'h3, 1, 3'h3, 16'h1234, scd_pkg::SCD_CMD_OPEN);
    chk({bank, bopen}, {3'h3, 8'h08}, "open bank");
    chk(row, 16'h1234, "row");
    cmd(4'h5, 1, 3'h3, 16'h0007, scd_pkg::SCD_CMD_RD);
    chk({chop, ac, bz}, 3'h5, "rd chop");
    chk(col, 10'h007, "col");
    fly = 1'b0;
    fc4 = 1'b1;
    cmd(4'h5, 1, 3'h3, 16'h1000, scd_pkg::SCD_CMD_RD);
    chk(chop, 1'b1, "fixed chop");
    fly = 1'b1;
    cmd(4'h4, 1, 3'h3, 16'h1403, scd_pkg::SCD_CMD_WR);
    chk({chop, ac, bopen}, {2'h1, 8'h00}, "wr autoclose");
    cmd(4'h3, 1, 3'h1, 16'h0001, scd_pkg::SCD_CMD_OPEN);
    cmd(4'h3, 1, 3'h5, 16'h0002, scd_pkg::SCD_CMD_OPEN);
    cmd(4'h2, 1, 3'h1, 16'h0000, scd_pkg::SCD_CMD_PRE);
    chk(bopen, 8'h20, "pre one");
    cmd(4'h2, 1, 3'h1, 16'h0400, scd_pkg::SCD_CMD_PRE_ALL);
    chk(bopen, 8'h00, "pre all");
    cmd(4'h6, 1, 3'h0, 16'h0400, scd_pkg::SCD_CMD_ZQL);
    cmd(4'h6, 1, 3'h0, 16'h0000, scd_pkg::SCD_CMD_ZQS);
    cmd(4'h1, 1, 3'h0, 16'h0000, scd_pkg::SCD_CMD_REF);
    cmd(4'h7, 1, 3'h0, 16'h0000, scd_pkg::SCD_CMD_NONE);
    cmd(4'h8, 1, 3'h0, 16'h0000, scd_pkg::SCD_CMD_NONE);
    cmd(4'h7, 0, 3'h0, 16'h0000, scd_pkg::SCD_CMD_PD_IN);
    chk(pwr, scd_pkg::SCD_ST_PD, "pd");
    cmd(4'h3, 0, 3'h2, 16'h0000, scd_pkg::SCD_CMD_NONE);
    chk({pwr, bopen}, {scd_pkg::SCD_ST_PD, 8'h00}, "pd hold");
    cmd(4'h7, 1, 3'h0, 16'h0000, scd_pkg::SCD_CMD_PD_OUT);
    chk(pwr, scd_pkg::SCD_ST_RUN, "pd exit");
    chk(idle, 1'b1, "idle");
    // No refresh ran in power-down, so one is owed now
    cmd(4'h1, 1, 3'h0, 16'h0000, scd_pkg::SCD_CMD_REF);
    cmd(4'h1, 0, 3'h0, 16'h0000, scd_pkg::SCD_CMD_SR_IN);
    chk(pwr, scd_pkg::SCD_ST_SR, "sr");
    cmd(4'h8, 1, 3'h0, 16'h0000, scd_pkg::SCD_CMD_SR_OUT);
    chk(pwr, scd_pkg::SCD_ST_RUN, "sr exit");
    summarize();
  end
endmodule
